/* File: src/iod_io_space_regs.svh */
// constants for the i/o space decoder and its scratch bytes
// assumes: included by bare name from the design modules
`ifndef IOD_IO_SPACE_REGS_SVH
`define IOD_IO_SPACE_REGS_SVH

// data-space placement of the short i/o window
`define IOD_IO_BASE 8'h20
`define IOD_IO_TOP 6'h3f
`define IOD_BIT_TOP 5'h1f
`define IOD_EXT_BASE 8'h60

// local registers, data-space addresses
`define IOD_ADDR_SCRATCH0 8'h3e
`define IOD_ADDR_SCRATCH1 8'h4a
`define IOD_ADDR_SCRATCH2 8'h4b
`define IOD_ADDR_FLAGS 8'h3c

// reset values
`define IOD_SCRATCH_RESET 8'h00
`define IOD_FLAGS_RESET 8'h00

`endif

/* File: src/iod_pkg.sv */
// types shared by the i/o space decoder files
// assumes: the constants header sits beside it
package iod_pkg;
  typedef logic [7:0] iod_byte_t;
  typedef logic [7:0] iod_addr_t;

  // kind of access taken in one cycle
  typedef enum logic [2:0] {
    ACC_NONE  = 3'b000,
    ACC_READ  = 3'b001,
    ACC_WRITE = 3'b010,
    ACC_SET   = 3'b011,
    ACC_CLR   = 3'b100,
    ACC_TEST  = 3'b101
  } iod_acc_t;
endpackage

/* File: src/iod_reg_if.sv */
// carrier between the decoder and one scratch byte
// assumes: one instance per scratch byte, all on the decoder clock
`timescale 1ns/10ps
`default_nettype none
interface iod_reg_if;
  logic wrEn;
  logic setEn;
  logic clrEn;
  logic [7:0] bitMask;
  logic [7:0] wrData;
  logic [7:0] value;

  modport dec (output wrEn, output setEn, output clrEn, output bitMask, output wrData,
    input value);
  modport store (input wrEn, input setEn, input clrEn, input bitMask, input wrData,
    output value);
endinterface
`default_nettype wire

/* File: src/iod_scratch_byte.sv */
// one 8-bit scratch byte with whole-byte write and single-bit set and clear
// assumes: strobes are one-hot per cycle and come from the decoder clock domain
`timescale 1ns/10ps
`default_nettype none
`include "iod_io_space_regs.svh"
module iod_scratch_byte (
  input wire logic clk,
  input wire logic rst_n,
  iod_reg_if.store port
);
  import iod_pkg::*;

  logic [7:0] value_r;

  // byte store, bit ops touch only the masked bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value_r <= `IOD_SCRATCH_RESET;
    end else if (port.wrEn) begin
      value_r <= port.wrData;
    end else if (port.setEn) begin
      value_r <= value_r | port.bitMask;
    end else if (port.clrEn) begin
      value_r <= value_r & ~port.bitMask;
    end
  end

  assign port.value = value_r;
endmodule // iod_scratch_byte
`default_nettype wire

/* File: src/iod_io_space_decode.sv */
// i/o space decoder: short i/o, bit ops and load/store onto one data-space map
// holds three scratch bytes and one write-one-to-clear flag byte; other
// peripherals sit behind the per* port and claim addresses with perMapped
// assumes: all request inputs come from core logic on clk, at most one a cycle
`timescale 1ns/10ps
`default_nettype none
`include "iod_io_space_regs.svh"
module iod_io_space_decode (
  input wire logic clk,
  input wire logic rst_n,
  // short i/o instructions
  input wire logic ioRdEn,
  input wire logic ioWrEn,
  input wire logic [5:0] ioAddr,
  // single-bit instructions
  input wire logic bitSetEn,
  input wire logic bitClrEn,
  input wire logic bitTestEn,
  input wire logic bitTestPol,
  input wire logic [4:0] bitAddr,
  input wire logic [2:0] bitSel,
  // load/store
  input wire logic memRdEn,
  input wire logic memWrEn,
  input wire iod_pkg::iod_addr_t memAddr,
  // shared write data
  input wire iod_pkg::iod_byte_t wrData,
  // answers
  output iod_pkg::iod_byte_t rdData,
  output logic rdValid,
  output logic testDone,
  output logic skipNext,
  // hardware events for the flag byte
  input wire iod_pkg::iod_byte_t eventIn,
  output iod_pkg::iod_byte_t flagsOut,
  // outer peripheral port
  output iod_pkg::iod_addr_t perAddr,
  output logic perRdEn,
  output logic perWrEn,
  output logic perBitSetEn,
  output logic perBitClrEn,
  output iod_pkg::iod_byte_t perBitMask,
  output iod_pkg::iod_byte_t perWrData,
  input wire logic perMapped,
  input wire iod_pkg::iod_byte_t perRdData
);
  import iod_pkg::*;

  // data-space addresses of the three scratch bytes
  localparam int NSCR = 3;
  localparam iod_addr_t SCR_ADDR [NSCR] = '{
    `IOD_ADDR_SCRATCH0,
    `IOD_ADDR_SCRATCH1,
    `IOD_ADDR_SCRATCH2
  };

  // decode, mux and answer state
  iod_acc_t kind;
  iod_addr_t addr;
  logic [2:0] bitIdx;
  logic [7:0] bitMask;
  logic [NSCR-1:0] hitScr;
  logic hitFlag;
  logic localHit;
  logic [7:0] scrVal [NSCR];
  logic [7:0] rdMux;
  logic [7:0] clearMask;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] rdData_r;
  logic rdValid_r;
  logic testDone_r;
  logic skipNext_r;

  // pick one request and turn its address into a data-space address
  // the core issues one request a cycle; should two meet, lower ones are dropped
  always_comb begin
    kind = ACC_NONE;
    addr = 8'h00;
    bitIdx = 3'h0;
    if (memRdEn && memAddr >= `IOD_IO_BASE) begin
      kind = ACC_READ;
      addr = memAddr;
    end else if (memWrEn && memAddr >= `IOD_IO_BASE) begin
      kind = ACC_WRITE;
      addr = memAddr;
    end else if (ioRdEn) begin
      kind = ACC_READ;
      addr = {2'b00, ioAddr} + `IOD_IO_BASE;
    end else if (ioWrEn) begin
      kind = ACC_WRITE;
      addr = {2'b00, ioAddr} + `IOD_IO_BASE;
    end else if (bitSetEn) begin
      kind = ACC_SET;
      addr = {3'b000, bitAddr} + `IOD_IO_BASE;
      bitIdx = bitSel;
    end else if (bitClrEn) begin
      kind = ACC_CLR;
      addr = {3'b000, bitAddr} + `IOD_IO_BASE;
      bitIdx = bitSel;
    end else if (bitTestEn) begin
      kind = ACC_TEST;
      addr = {3'b000, bitAddr} + `IOD_IO_BASE;
      bitIdx = bitSel;
    end
  end

  // one-hot mask of the addressed bit
  assign bitMask = 8'h01 << bitIdx;

  // scratch bytes, one generated store each
  genvar g;
  generate
    for (g = 0; g < NSCR; g++) begin : gScr
      iod_reg_if scr ();
      assign hitScr[g] = (addr == SCR_ADDR[g]) && (kind != ACC_NONE);
      assign scr.wrEn = hitScr[g] && (kind == ACC_WRITE);
      assign scr.setEn = hitScr[g] && (kind == ACC_SET);
      assign scr.clrEn = hitScr[g] && (kind == ACC_CLR);
      assign scr.bitMask = bitMask;
      assign scr.wrData = wrData;
      assign scrVal[g] = scr.value;
      // byte store, whole-byte write and masked bit ops
      iod_scratch_byte iod_scratch_byte_inst (
        .clk(clk),
        .rst_n(rst_n),
        .port(scr.store)
      );
    end
  endgenerate

  // hits on the local bytes keep the request away from the outer port
  assign hitFlag = (addr == `IOD_ADDR_FLAGS) && (kind != ACC_NONE);
  assign localHit = (|hitScr) || hitFlag;

  // read mux, unclaimed addresses give zero
  always_comb begin
    rdMux = 8'h00;
    if (hitFlag) begin
      rdMux = flags_r;
    end else if (|hitScr) begin
      for (int i = 0; i < NSCR; i++) begin
        if (hitScr[i]) begin
          rdMux = scrVal[i];
        end
      end
    end else if (perMapped) begin
      rdMux = perRdData;
    end
  end

  // ones written to the flag byte clear; a bit set writes a one to one bit only
  always_comb begin
    clearMask = 8'h00;
    if (hitFlag && kind == ACC_WRITE) begin
      clearMask = wrData;
    end else if (hitFlag && kind == ACC_SET) begin
      clearMask = bitMask;
    end
    flags_nxt = (flags_r & ~clearMask) | eventIn; // set wins over clear
  end

  // flag byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= `IOD_FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // read answer, one cycle after the request
  // rdData holds until the next read so a slow core can still pick it up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= (kind == ACC_READ);
      if (kind == ACC_READ) begin
        rdData_r <= rdMux;
      end
    end
  end

  // bit test answer, one cycle after the request
  // skipNext holds until the next test
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      testDone_r <= 1'b0;
      skipNext_r <= 1'b0;
    end else begin
      testDone_r <= (kind == ACC_TEST);
      if (kind == ACC_TEST) begin
        skipNext_r <= (rdMux[bitIdx] == bitTestPol);
      end
    end
  end

  // registered answers and flag byte to the ports
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign testDone = testDone_r;
  assign skipNext = skipNext_r;
  assign flagsOut = flags_r;

  // outer peripherals: writes only reach a claimed address
  // reads and tests go out unclaimed too; the zero answer comes from the mux
  assign perAddr = addr;
  assign perWrData = wrData;
  assign perBitMask = bitMask;
  assign perRdEn = (kind == ACC_READ || kind == ACC_TEST) && !localHit;
  assign perWrEn = (kind == ACC_WRITE) && !localHit && perMapped;
  assign perBitSetEn = (kind == ACC_SET) && !localHit && perMapped;
  assign perBitClrEn = (kind == ACC_CLR) && !localHit && perMapped;
endmodule // iod_io_space_decode
`default_nettype wire

/* File: bench/iod_io_space_decode_sva.sv */
// checks on the decoder top ports
// assumes: bound to iod_io_space_decode, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module iod_io_space_decode_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ioRdEn,
  input wire logic [5:0] ioAddr,
  input wire logic bitTestEn,
  input wire logic memRdEn,
  input wire logic memWrEn,
  input wire logic [7:0] memAddr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic testDone,
  input wire logic skipNext,
  input wire logic [7:0] eventIn,
  input wire logic [7:0] flagsOut,
  input wire logic [7:0] perAddr,
  input wire logic perWrEn,
  input wire logic perRdEn,
  input wire logic perBitSetEn,
  input wire logic perBitClrEn,
  input wire logic [7:0] perBitMask,
  input wire logic perMapped
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a load taken from the data window
  sequence s_mem_rd;
    memRdEn && memAddr >= 8'h20;
  endsequence
  a_mem_read_ans: assert property (s_mem_rd |=> rdValid)
    else $error("load got no answer");
  a_no_read_quiet: assert property (!ioRdEn && !(memRdEn && memAddr >= 8'h20) |=> !rdValid)
    else $error("answer without a read");
  a_no_test_quiet: assert property (!bitTestEn |=> !testDone)
    else $error("test answer without a test");
  a_skip_held: assert property (!testDone && $past(rst_n) |-> $stable(skipNext))
    else $error("skip flag moved without a test");
  a_unmapped_zero: assert property (s_mem_rd ##0 (memAddr >= 8'h60 && !perMapped)
    |=> rdData == 8'h00) else $error("unmapped read not zero");
  a_ext_write: assert property (memWrEn && !memRdEn && memAddr >= 8'h60
    |-> perWrEn == perMapped) else $error("extended store not passed out");
  a_io_offset: assert property (ioRdEn && !memRdEn && !memWrEn
    |-> perAddr == {2'b00, ioAddr} + 8'h20) else $error("i/o offset wrong");
  a_flag_w1c: assert property (memWrEn && !memRdEn && memAddr == 8'h3c
    |=> flagsOut == ($past(flagsOut) & ~$past(wrData) | $past(eventIn)))
    else $error("flag byte clear wrong");
  a_bit_range: assert property (perBitSetEn || perBitClrEn |-> perAddr <= 8'h3f)
    else $error("bit op outside bit range");
  a_bit_onehot: assert property (perBitSetEn || perBitClrEn |-> $onehot(perBitMask))
    else $error("bit op mask not one bit");
  a_ext_read: assert property (memRdEn && memAddr >= 8'h60 |-> perRdEn)
    else $error("extended load not passed out");
endmodule // iod_io_space_decode_sva
`default_nettype wire

/* File: bench/iod_per_model.sv */
// outer peripheral model: two bytes at two claimed data addresses
// assumes: decoder per* strobes on the same clock
`timescale 1ns/10ps
`default_nettype none
module iod_per_model #(parameter logic [7:0] ADDR = 8'h80, parameter logic [7:0] BIT_ADDR = 8'h30) (
  input wire logic clk,
  input wire logic [7:0] perAddr,
  input wire logic perWrEn,
  input wire logic perBitSetEn,
  input wire logic perBitClrEn,
  input wire logic [7:0] perBitMask,
  input wire logic [7:0] perWrData,
  output logic perMapped,
  output logic [7:0] perRdData
);
  logic [7:0] store_r = 8'h00;
  logic [7:0] bitStore_r = 8'h00;
  logic hitByte, hitBit;
  // claim one extended and one bit-accessible address, show junk elsewhere
  assign hitByte = perAddr == ADDR;
  assign hitBit = perAddr == BIT_ADDR;
  assign perMapped = hitByte || hitBit;
  assign perRdData = hitByte ? store_r : (hitBit ? bitStore_r : ~store_r);
  // whole-byte stores, bit ops on the low byte only
  always @(posedge clk) begin
    if (perWrEn && hitByte) store_r <= perWrData;
    if (perWrEn && hitBit) begin
      bitStore_r <= perWrData;
    end else if (perBitSetEn && hitBit) begin
      bitStore_r <= bitStore_r | perBitMask;
    end else if (perBitClrEn && hitBit) begin
      bitStore_r <= bitStore_r & ~perBitMask;
    end
  end
endmodule // iod_per_model
`default_nettype wire

/* File: bench/iod_io_space_decode_test.sv */
// self-checking bench for the i/o space decoder
// assumes: design, checker and outer model compiled first
`timescale 1ns/10ps
`default_nettype none
module iod_io_space_decode_test;
  import iod_pkg::*;
  localparam logic [6:0] IR = 7'h40, IW = 7'h20, MR = 7'h10, MW = 7'h08;
  localparam logic [6:0] BS = 7'h04, BC = 7'h02, BT = 7'h01;
  logic clk = 1'b0, rst_n = 1'b0;
  logic ioRdEn, ioWrEn, bitSetEn, bitClrEn, bitTestEn, bitTestPol, memRdEn, memWrEn;
  logic rdValid, testDone, skipNext, perRdEn, perWrEn, perBitSetEn, perBitClrEn, perMapped;
  logic [5:0] ioAddr;
  logic [4:0] bitAddr;
  logic [2:0] bitSel;
  iod_addr_t memAddr, perAddr;
  iod_byte_t wrData, rdData, eventIn, flagsOut, perBitMask, perWrData, perRdData;
  iod_byte_t sAddr [3] = '{8'h1e, 8'h2a, 8'h2b};
  int failures = 0, nTests = 0;
  iod_io_space_decode iod_io_space_decode_inst (.*);
  iod_per_model iod_per_model_inst (.*);
  always #2 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t flag got %b want %b", $time, g, e);
    end
  endtask
  // one request for one cycle, answers settled on return
  task automatic req(input logic [6:0] en, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {ioRdEn, ioWrEn, memRdEn, memWrEn, bitSetEn, bitClrEn, bitTestEn} <= en;
    ioAddr <= a[5:0];
    bitAddr <= a[4:0];
    memAddr <= a;
    wrData <= d;
    {bitTestPol, bitSel} <= d[3:0];
    @(posedge clk);
    {ioRdEn, ioWrEn, memRdEn, memWrEn, bitSetEn, bitClrEn, bitTestEn} <= 7'h00;
    #1;
  endtask
  task automatic rd(input logic [6:0] en, input logic [7:0] a, input logic [7:0] e);
    req(en, a, 8'h00);
    chk_bit(rdValid, 1'b1);
    chk(rdData, e);
  endtask
  task automatic tst(input logic [7:0] a, input logic [3:0] ps, input logic e);
    req(BT, a, {4'h0, ps}); // spare bits zero
    chk_bit(testDone, 1'b1);
    chk_bit(skipNext, e);
  endtask
  task automatic t_scratch;
    for (int i = 0; i < 3; i++) rd(IR, sAddr[i], 8'h00);
    for (iod_byte_t i = 8'h00; i < 8'h03; i++) begin
      req(IW, sAddr[i], 8'h5a + i);
      rd(MR, sAddr[i] + 8'h20, 8'h5a + i);
      req(MW, sAddr[i] + 8'h20, 8'hc3 - i);
      rd(IR, sAddr[i], 8'hc3 - i);
    end
    $display("test scratch done");
  endtask
  task automatic t_bits;
    req(IW, 8'h1e, 8'h00);
    req(BS, 8'h1e, 8'h02);
    req(BS, 8'h1e, 8'h07);
    req(BC, 8'h1e, 8'h02);
    rd(IR, 8'h1e, 8'h80);
    tst(8'h1e, 4'hf, 1'b1);
    tst(8'h1e, 4'h8, 1'b0);
    tst(8'h1e, 4'h0, 1'b1);
    $display("test bits done");
  endtask
  task automatic t_flags;
    @(posedge clk);
    eventIn <= 8'h0f;
    @(posedge clk);
    eventIn <= 8'h00;
    rd(IR, 8'h1c, 8'h0f);
    req(MW, 8'h3c, 8'h01);
    req(MW, 8'h3c, 8'h00);
    req(BS, 8'h1c, 8'h01);
    req(BC, 8'h1c, 8'h02);
    chk(flagsOut, 8'h0c);
    @(posedge clk);
    eventIn <= 8'h04;
    req(MW, 8'h3c, 8'h04);
    chk(flagsOut, 8'h0c);
    @(posedge clk);
    eventIn <= 8'h00;
    rd(MR, 8'h3c, 8'h0c);
    $display("test flags done");
  endtask
  task automatic t_outer;
    req(MW, 8'h80, 8'h3c);
    rd(MR, 8'h80, 8'h3c);
    rd(MR, 8'h90, 8'h00);
    rd(IR, 8'h3f, 8'h00);
    req(IW, 8'h10, 8'ha5);
    req(BS, 8'h10, 8'h01);
    req(BC, 8'h10, 8'h05);
    rd(IR, 8'h10, 8'h87);
    tst(8'h10, 4'hf, 1'b1);
    req(MR, 8'h10, 8'h00);
    chk_bit(rdValid, 1'b0);
    $display("test outer done");
  endtask
  task automatic t_reset;
    req(IW, 8'h2b, 8'h77);
    rd(IR, 8'h2b, 8'h77);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_bit(skipNext, 1'b0);
    chk(flagsOut, 8'h00);
    rd(MR, 8'h4b, 8'h00);
    $display("test reset done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    {ioRdEn, ioWrEn, memRdEn, memWrEn, bitSetEn, bitClrEn, bitTestEn, bitTestPol} = 8'h00;
    {ioAddr, bitAddr, bitSel} = 14'h0000;
    memAddr = 8'h00;
    wrData = 8'h00;
    eventIn = 8'h00;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_scratch();
    t_bits();
    t_flags();
    t_outer();
    t_reset();
    print_verdict();
  end
endmodule // iod_io_space_decode_test
bind iod_io_space_decode iod_io_space_decode_sva iod_io_space_decode_sva_inst (.*);
`default_nettype wire
